//--- rtl/sgm_top.sv
// signal modulator: registers, source muxes and modulated output
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module sgm_top (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // peripheral disable from the power unit
   input wire logic module_power_disable_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // remapped input pins
   input wire logic source_pin_remap_i,
   input wire logic high_carrier_pin_remap_i,
   input wire logic low_carrier_pin_remap_i,
   // clocks offered as carriers
   input wire logic system_clock_source_i,
   input wire logic internal_fast_oscillator_i,
   input wire logic reference_clock_output_i,
   // peripheral outputs
   input wire logic capture_compare_1_i,
   input wire logic capture_compare_2_i,
   input wire logic pwm_unit_3_i,
   input wire logic pwm_unit_4_i,
   input wire logic comparator_1_i,
   input wire logic comparator_2_i,
   input wire logic uart_1_rx_data_i,
   input wire logic uart_1_tx_i,
   input wire logic uart_2_rx_data_i,
   input wire logic uart_2_tx_i,
   input wire logic serial_port_1_sdo_i,
   input wire logic serial_port_2_sdo_i,
   // modulated output
   output logic modulated_output_pin_o
);
   // register state
   logic enable_r;
   logic output_invert_r;
   logic software_modulation_bit_r;
   logic high_carrier_invert_r;
   logic high_carrier_sync_enable_r;
   logic low_carrier_invert_r;
   logic low_carrier_sync_enable_r;
   logic [3:0] modulator_source_field_r;
   logic [2:0] low_carrier_select_field_r;
   logic [2:0] high_carrier_select_field_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic out_r;
   logic out_nxt;
   // datapath
   logic clear_regs;
   logic run;
   logic wr_ok;
   logic mod_sel;
   logic high_raw;
   logic low_raw;
   logic high_carrier;
   logic low_carrier;
   logic sel_high;
   logic mixed;

   // power disable holds every register of this module at its reset value
   assign clear_regs = rst_i | module_power_disable_i;
   assign wr_ok = wr_i & ~module_power_disable_i;
   assign run = enable_r & ~module_power_disable_i;

   // control 0: enable, invert, software bit
   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         enable_r <= sgm_pkg::RST_CTRL0[sgm_pkg::C0_EN];
         output_invert_r <= sgm_pkg::RST_CTRL0[sgm_pkg::C0_OINV];
         software_modulation_bit_r <=
            sgm_pkg::RST_CTRL0[sgm_pkg::C0_SWBIT];
      end else if (wr_ok && addr_i == sgm_pkg::ADDR_CTRL0) begin
         enable_r <= wdata_i[sgm_pkg::C0_EN];
         output_invert_r <= wdata_i[sgm_pkg::C0_OINV];
         software_modulation_bit_r <=
            wdata_i[sgm_pkg::C0_SWBIT];
      end
   end

   // control 1: carrier polarity and sync
   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         high_carrier_invert_r <= sgm_pkg::RST_CTRL1[sgm_pkg::C1_HINV];
         high_carrier_sync_enable_r <=
            sgm_pkg::RST_CTRL1[sgm_pkg::C1_HSYNC];
         low_carrier_invert_r <= sgm_pkg::RST_CTRL1[sgm_pkg::C1_LINV];
         low_carrier_sync_enable_r <=
            sgm_pkg::RST_CTRL1[sgm_pkg::C1_LSYNC];
      end else if (wr_ok && addr_i == sgm_pkg::ADDR_CTRL1) begin
         high_carrier_invert_r <= wdata_i[sgm_pkg::C1_HINV];
         high_carrier_sync_enable_r <=
            wdata_i[sgm_pkg::C1_HSYNC];
         low_carrier_invert_r <= wdata_i[sgm_pkg::C1_LINV];
         low_carrier_sync_enable_r <=
            wdata_i[sgm_pkg::C1_LSYNC];
      end
   end

   // source selections are untouched by the enable bit
   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         modulator_source_field_r <= sgm_pkg::RST_SRC;
      end else if (wr_ok && addr_i == sgm_pkg::ADDR_SRC) begin
         modulator_source_field_r <= wdata_i[sgm_pkg::SRC_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         low_carrier_select_field_r <= sgm_pkg::RST_CAR;
      end else if (wr_ok && addr_i == sgm_pkg::ADDR_LOW_CARRIER) begin
         low_carrier_select_field_r <= wdata_i[sgm_pkg::CAR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         high_carrier_select_field_r <= sgm_pkg::RST_CAR;
      end else if (wr_ok && addr_i == sgm_pkg::ADDR_HIGH_CARRIER) begin
         high_carrier_select_field_r <= wdata_i[sgm_pkg::CAR_W-1:0];
      end
   end

   // modulator source mux
   always_comb begin
      case (modulator_source_field_r)
         sgm_pkg::SRC_PIN: mod_sel = source_pin_remap_i;
         sgm_pkg::SRC_SWBIT: mod_sel = software_modulation_bit_r;
         sgm_pkg::SRC_CC1: mod_sel = capture_compare_1_i;
         sgm_pkg::SRC_CC2: mod_sel = capture_compare_2_i;
         sgm_pkg::SRC_PWM_UNIT_3: mod_sel = pwm_unit_3_i;
         sgm_pkg::SRC_PWM4: mod_sel = pwm_unit_4_i;
         sgm_pkg::SRC_COMPARATOR_1: mod_sel = comparator_1_i;
         sgm_pkg::SRC_CMP2: mod_sel = comparator_2_i;
         sgm_pkg::SRC_U1RX: mod_sel = uart_1_rx_data_i;
         sgm_pkg::SRC_U1TX: mod_sel = uart_1_tx_i;
         sgm_pkg::SRC_U2RX: mod_sel = uart_2_rx_data_i;
         sgm_pkg::SRC_U2TX: mod_sel = uart_2_tx_i;
         sgm_pkg::SRC_SP1: mod_sel = serial_port_1_sdo_i;
         sgm_pkg::SRC_SP2: mod_sel = serial_port_2_sdo_i;
         default: mod_sel = 1'b0;
      endcase
   end

   // high carrier source mux
   always_comb begin
      case (high_carrier_select_field_r)
         sgm_pkg::CAR_PIN: high_raw = high_carrier_pin_remap_i;
         sgm_pkg::CAR_SYSCLK: high_raw = system_clock_source_i;
         sgm_pkg::CAR_SYSTEM_CLOCK_SOURCE: high_raw = internal_fast_oscillator_i;
         sgm_pkg::CAR_REFCLK: high_raw = reference_clock_output_i;
         sgm_pkg::CAR_CC1: high_raw = capture_compare_1_i;
         sgm_pkg::CAR_CC2: high_raw = capture_compare_2_i;
         sgm_pkg::CAR_PWM_UNIT_3: high_raw = pwm_unit_3_i;
         sgm_pkg::CAR_PWM4: high_raw = pwm_unit_4_i;
         default: high_raw = 1'b0;
      endcase
   end

   // low carrier source mux, own remapped pin on code zero
   always_comb begin
      case (low_carrier_select_field_r)
         sgm_pkg::CAR_PIN: low_raw = low_carrier_pin_remap_i;
         sgm_pkg::CAR_SYSCLK: low_raw = system_clock_source_i;
         sgm_pkg::CAR_SYSTEM_CLOCK_SOURCE: low_raw = internal_fast_oscillator_i;
         sgm_pkg::CAR_REFCLK: low_raw = reference_clock_output_i;
         sgm_pkg::CAR_CC1: low_raw = capture_compare_1_i;
         sgm_pkg::CAR_CC2: low_raw = capture_compare_2_i;
         sgm_pkg::CAR_PWM_UNIT_3: low_raw = pwm_unit_3_i;
         sgm_pkg::CAR_PWM4: low_raw = pwm_unit_4_i;
         default: low_raw = 1'b0;
      endcase
   end

   // carrier polarity before mixing
   assign high_carrier = high_raw ^ high_carrier_invert_r;
   assign low_carrier = low_raw ^ low_carrier_invert_r;

   sgm_carrier_switch u_switch (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .high_carrier_sync_enable_i(high_carrier_sync_enable_r),
      .low_carrier_sync_enable_i(low_carrier_sync_enable_r),
      .mod_i(mod_sel),
      .high_carrier_i(high_carrier),
      .low_carrier_i(low_carrier),
      .sel_high_o(sel_high)
   );

   // mixing runs on every clock, sleep does not gate it
   assign mixed = sel_high ? high_carrier : low_carrier;

   always_comb begin
      if (run) begin
         out_nxt = mixed ^ output_invert_r;
      end else begin
         out_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (clear_regs) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign modulated_output_pin_o = out_r;

   // read data stands only in the cycle after the strobe
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_i && !module_power_disable_i) begin
         case (addr_i)
            sgm_pkg::ADDR_CTRL0: begin
               rdata_nxt[sgm_pkg::C0_EN] = enable_r;
               rdata_nxt[sgm_pkg::C0_OUT] = out_r;
               rdata_nxt[sgm_pkg::C0_OINV] = output_invert_r;
               rdata_nxt[sgm_pkg::C0_SWBIT] = software_modulation_bit_r;
            end
            sgm_pkg::ADDR_CTRL1: begin
               rdata_nxt[sgm_pkg::C1_HINV] = high_carrier_invert_r;
               rdata_nxt[sgm_pkg::C1_HSYNC] = high_carrier_sync_enable_r;
               rdata_nxt[sgm_pkg::C1_LINV] = low_carrier_invert_r;
               rdata_nxt[sgm_pkg::C1_LSYNC] = low_carrier_sync_enable_r;
            end
            sgm_pkg::ADDR_SRC: begin
               rdata_nxt[sgm_pkg::SRC_W-1:0] = modulator_source_field_r;
            end
            sgm_pkg::ADDR_LOW_CARRIER: begin
               rdata_nxt[sgm_pkg::CAR_W-1:0] = low_carrier_select_field_r;
            end
            sgm_pkg::ADDR_HIGH_CARRIER: begin
               rdata_nxt[sgm_pkg::CAR_W-1:0] = high_carrier_select_field_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o = rdata_r;
endmodule

//--- rtl/sgm_pkg.sv
// constants of the signal modulator: register map, fields, codes
// Notes on behaviour
// - output is selected carrier gated by modulator
// - modulator high uses high carrier, else low
// - enable bit 7 low holds output low
// - disable keeps source selections unchanged
// - modulator codes 0000 to 0111 mapping
// - modulator codes 1000 to 1101, rest reserved
// - high carrier select eight-way mapping
// - low carrier uses same mapping, own pin
// - synced carrier pulse finishes before switching
// - separate sync enables per carrier
// - each carrier has its own invert bit
// - output invert bit 4 flips output, disabled output stays low
// - bit 0 is software modulator input
// - bit 5 reads current modulated output
// - reset disables and clears all registers
// - power disable resets and stops module
// - keeps modulating while sources keep running
// - registers at 0x0F51 through 0x0F55
// - high sync waits high carrier falling edge
// - low sync waits low carrier falling edge
package sgm_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL0 = 12'hF51;
   localparam logic [11:0] ADDR_CTRL1 = 12'hF52;
   localparam logic [11:0] ADDR_SRC = 12'hF53;
   localparam logic [11:0] ADDR_LOW_CARRIER = 12'hF54;
   localparam logic [11:0] ADDR_HIGH_CARRIER = 12'hF55;
   // control 0 fields
   localparam int C0_EN = 7;
   localparam int C0_OUT = 5;
   localparam int C0_OINV = 4;
   localparam int C0_SWBIT = 0;
   // control 1 fields
   localparam int C1_HINV = 5;
   localparam int C1_HSYNC = 4;
   localparam int C1_LINV = 1;
   localparam int C1_LSYNC = 0;
   // select field widths
   localparam int SRC_W = 4;
   localparam int CAR_W = 3;
   // reset values
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [3:0] RST_SRC = 4'h0;
   localparam logic [2:0] RST_CAR = 3'h0;
   // modulator source codes
   localparam logic [3:0] SRC_PIN = 4'h0;
   localparam logic [3:0] SRC_SWBIT = 4'h1;
   localparam logic [3:0] SRC_CC1 = 4'h2;
   localparam logic [3:0] SRC_CC2 = 4'h3;
   localparam logic [3:0] SRC_PWM_UNIT_3 = 4'h4;
   localparam logic [3:0] SRC_PWM4 = 4'h5;
   localparam logic [3:0] SRC_COMPARATOR_1 = 4'h6;
   localparam logic [3:0] SRC_CMP2 = 4'h7;
   localparam logic [3:0] SRC_U1RX = 4'h8;
   localparam logic [3:0] SRC_U1TX = 4'h9;
   localparam logic [3:0] SRC_U2RX = 4'hA;
   localparam logic [3:0] SRC_U2TX = 4'hB;
   localparam logic [3:0] SRC_SP1 = 4'hC;
   localparam logic [3:0] SRC_SP2 = 4'hD;
   // carrier source codes
   localparam logic [2:0] CAR_PIN = 3'h0;
   localparam logic [2:0] CAR_SYSCLK = 3'h1;
   localparam logic [2:0] CAR_SYSTEM_CLOCK_SOURCE = 3'h2;
   localparam logic [2:0] CAR_REFCLK = 3'h3;
   localparam logic [2:0] CAR_CC1 = 3'h4;
   localparam logic [2:0] CAR_CC2 = 3'h5;
   localparam logic [2:0] CAR_PWM_UNIT_3 = 3'h6;
   localparam logic [2:0] CAR_PWM4 = 3'h7;
   // carrier switch states, gray along low-high-low
   typedef enum logic [1:0] {
      SGM_LOW = 2'h0,
      SGM_TO_HIGH = 2'h1,
      SGM_HIGH = 2'h3,
      SGM_TO_LOW = 2'h2
   } sgm_state_t;
endpackage

//--- rtl/sgm_carrier_switch.sv
// carrier switch: picks high or low carrier with optional sync
`timescale 1ns/10ps
module sgm_carrier_switch (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic high_carrier_sync_enable_i,
   input wire logic low_carrier_sync_enable_i,
   // signals
   input wire logic mod_i,
   input wire logic high_carrier_i,
   input wire logic low_carrier_i,
   output logic sel_high_o
);
   sgm_pkg::sgm_state_t state_r;
   sgm_pkg::sgm_state_t state_nxt;
   logic high_prev_r;
   logic low_prev_r;
   logic high_fall;
   logic low_fall;

   assign high_fall = high_prev_r & ~high_carrier_i;
   assign low_fall = low_prev_r & ~low_carrier_i;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         high_prev_r <= 1'b0;
         low_prev_r <= 1'b0;
      end else begin
         high_prev_r <= high_carrier_i;
         low_prev_r <= low_carrier_i;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sgm_pkg::SGM_LOW: begin
            if (mod_i) begin
               if (low_carrier_sync_enable_i) begin
                  state_nxt = sgm_pkg::SGM_TO_HIGH;
               end else begin
                  state_nxt = sgm_pkg::SGM_HIGH;
               end
            end
         end
         sgm_pkg::SGM_TO_HIGH: begin
            if (!mod_i) begin
               state_nxt = sgm_pkg::SGM_LOW;
            end else if (low_fall) begin
               state_nxt = sgm_pkg::SGM_HIGH;
            end
         end
         sgm_pkg::SGM_HIGH: begin
            if (!mod_i) begin
               if (high_carrier_sync_enable_i) begin
                  state_nxt = sgm_pkg::SGM_TO_LOW;
               end else begin
                  state_nxt = sgm_pkg::SGM_LOW;
               end
            end
         end
         sgm_pkg::SGM_TO_LOW: begin
            if (mod_i) begin
               state_nxt = sgm_pkg::SGM_HIGH;
            end else if (high_fall) begin
               state_nxt = sgm_pkg::SGM_LOW;
            end
         end
         default: begin
            state_nxt = sgm_pkg::SGM_LOW;
         end
      endcase
      if (!run_i) begin
         state_nxt = sgm_pkg::SGM_LOW;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r <= sgm_pkg::SGM_LOW;
      end else begin
         state_r <= state_nxt;
      end
   end

   // high carrier is mixed while switched to, or while its pulse drains
   assign sel_high_o = (state_nxt == sgm_pkg::SGM_HIGH) ||
                       (state_nxt == sgm_pkg::SGM_TO_LOW);
endmodule

//--- tb/sgm_chk.sv
// port checker of the signal modulator, bound to its top
`timescale 1ns/10ps
module sgm_chk (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // power disable and register port
   input wire logic module_power_disable_i,
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // modulated output
   input wire logic modulated_output_pin_o
);
   logic en_q;
   logic c0_rd;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   assign c0_rd = rd_i && !module_power_disable_i
      && addr_i == sgm_pkg::ADDR_CTRL0;
   // enable bit as software last wrote it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || module_power_disable_i) begin
         en_q <= 1'b0;
      end else if (wr_i && addr_i == sgm_pkg::ADDR_CTRL0) begin
         en_q <= wdata_i[sgm_pkg::C0_EN];
      end
   end
   rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read cycle");
   reset_clear_a: assert property (disable iff (1'b0)
      rst_i |=> !modulated_output_pin_o && rdata_o == 8'h00)
      else $error("reset left output or data set");
   pmd_off_a: assert property (module_power_disable_i |=>
      !modulated_output_pin_o && rdata_o == 8'h00)
      else $error("power disable left output or data set");
   en_off_a: assert property ((!en_q) [*2]
      |-> !modulated_output_pin_o) else $error("output while disabled");
   en_read_a: assert property (c0_rd |=> rdata_o[7] == $past(en_q))
      else $error("enable bit read wrong");
   out_read_a: assert property (c0_rd |=>
      rdata_o[5] == $past(modulated_output_pin_o))
      else $error("status bit differs from output");
   c0_rsv_a: assert property (c0_rd |=> rdata_o[6] == 1'b0
      && rdata_o[3:1] == 3'h0) else $error("control reserved bits set");
   car_rsv_a: assert property (rd_i && addr_i >= sgm_pkg::ADDR_LOW_CARRIER
      |=> rdata_o[7:3] == 5'h00) else $error("carrier reserved bits set");
   unmapped_a: assert property (rd_i && (addr_i < sgm_pkg::ADDR_CTRL0
      || addr_i > sgm_pkg::ADDR_HIGH_CARRIER) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind sgm_top sgm_chk u_chk (.ref_clk_i, .rst_i, .module_power_disable_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .modulated_output_pin_o);

//--- tb/sgm_src_model.sv
// model of the peripherals and clocks that feed the modulator
`timescale 1ns/10ps
module sgm_src_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // clock and peripheral outputs, one bit each
   output logic [14:0] sig_o
);
   logic [15:0] lfsr_r;
   // sources run on in every mode, each bit the same stream one cycle later than the bit below
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lfsr_r <= 16'hACE1;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]
            ^ lfsr_r[10]};
      end
   end
   assign sig_o = lfsr_r[14:0];
endmodule

//--- tb/tb_sgm_top.sv
// self-checking bench of the signal modulator
`timescale 1ns/10ps
`define CHK(a, b) begin \
   comparisons++; \
   if ((a) !== (b)) begin \
      fail_count++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
   end \
end
module tb_sgm_top;
   localparam logic [11:0] A_C0 = sgm_pkg::ADDR_CTRL0;
   localparam logic [11:0] A_C1 = sgm_pkg::ADDR_CTRL1;
   localparam logic [11:0] A_SRC = sgm_pkg::ADDR_SRC;
   localparam logic [11:0] A_CL = sgm_pkg::ADDR_LOW_CARRIER;
   localparam logic [11:0] A_CH = sgm_pkg::ADDR_HIGH_CARRIER;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic peripheral_disable_unit = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic ps = 1'b0;
   logic ph = 1'b0;
   logic pl = 1'b0;
   logic pin_auto = 1'b0;
   logic [14:0] s;
   logic modulated_output_pin_o;
   logic exp_q;
   logic [2:0] pcnt = 3'h0;
   logic [7:0] m [0:4] = '{default: 8'h00};
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   sgm_src_model u_src (.ref_clk_i, .rst_i, .sig_o(s));
   sgm_top u_dut (.ref_clk_i, .rst_i, .module_power_disable_i(peripheral_disable_unit),
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .source_pin_remap_i(ps),
      .high_carrier_pin_remap_i(ph), .low_carrier_pin_remap_i(pl),
      .system_clock_source_i(s[0]), .internal_fast_oscillator_i(s[1]),
      .reference_clock_output_i(s[2]), .capture_compare_1_i(s[3]),
      .capture_compare_2_i(s[4]), .pwm_unit_3_i(s[5]), .pwm_unit_4_i(s[6]),
      .comparator_1_i(s[7]), .comparator_2_i(s[8]),
      .uart_1_rx_data_i(s[9]), .uart_1_tx_i(s[10]),
      .uart_2_rx_data_i(s[11]), .uart_2_tx_i(s[12]),
      .serial_port_1_sdo_i(s[13]), .serial_port_2_sdo_i(s[14]),
      .modulated_output_pin_o);
   function automatic logic car(input logic [2:0] c, input logic p);
      car = (c == 3'h0) ? p : s[c - 3'h1];
   endfunction
   // expected output from the inputs seen at this edge, no sync in use
   function automatic logic pred();
      logic md;
      md = (m[2][3:0] == 4'h0) ? ps : (m[2][3:0] == 4'h1) ? m[0][0] :
         (m[2][3:0] > 4'hD) ? 1'b0 : s[m[2][3:0] + 4'h1];
      pred = (m[0][7] && !peripheral_disable_unit && !rst_i) ? ((md ? car(m[4][2:0], ph)
         ^ m[1][5] : car(m[3][2:0], pl) ^ m[1][1]) ^ m[0][4]) : 1'b0;
   endfunction
   always @(posedge ref_clk_i) begin
      exp_q <= pred();
      pcnt <= pcnt + 3'h1;
      if (pin_auto) begin
         ps <= pcnt[1];
         ph <= pcnt[0];
         pl <= pcnt[2];
      end
      if (rst_i || peripheral_disable_unit) begin
         m <= '{default: 8'h00};
      end
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      if (!peripheral_disable_unit && a >= A_C0 && a <= A_CH) begin
         m[a - A_C0] <= d;
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK(rdata_o, e)
   endtask
   task automatic watch(input int n);
      repeat (n) begin
         @(negedge ref_clk_i);
         `CHK(modulated_output_pin_o, exp_q)
      end
      @(posedge ref_clk_i);
   endtask
   task automatic out_is(input logic e);
      repeat (3) @(negedge ref_clk_i);
      `CHK(modulated_output_pin_o, e)
      @(posedge ref_clk_i);
   endtask
   task automatic t_regs();
      for (int i = 0; i < 7; i++) begin
         rd_chk(12'hF50 + i[11:0], 8'h00);
      end
      wr_reg(A_C0, 8'h7F);
      wr_reg(A_C1, 8'hFF);
      wr_reg(A_SRC, 8'hFF);
      wr_reg(A_CL, 8'hFF);
      wr_reg(A_CH, 8'hFF);
      wr_reg(12'hF56, 8'hFF);
      watch(4);
      rd_chk(A_C0, 8'h11);
      rd_chk(A_C1, 8'h33);
      rd_chk(A_SRC, 8'h0F);
      rd_chk(A_CL, 8'h07);
      rd_chk(A_CH, 8'h07);
      rd_chk(12'hF56, 8'h00);
   endtask
   task automatic t_mux();
      pin_auto <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         wr_reg(A_SRC, {4'h0, i[3:0]});
         wr_reg(A_CH, {5'h00, i[2:0]});
         wr_reg(A_CL, {5'h00, ~i[2:0]});
         wr_reg(A_C1, {2'h0, i[1], 3'h0, i[2], 1'b0});
         wr_reg(A_C0, {3'h4, i[3], 3'h0, ~i[3]});
         watch(12);
      end
   endtask
   task automatic t_enable();
      wr_reg(A_C0, 8'h10);
      watch(8);
      rd_chk(A_SRC, 8'h0F);
      wr_reg(A_C0, 8'h90);
      watch(8);
      pin_auto <= 1'b0;
   endtask
   task automatic t_soft();
      wr_reg(A_C1, 8'h00);
      ph <= 1'b1;
      pl <= 1'b0;
      wr_reg(A_SRC, 8'h01);
      wr_reg(A_CH, 8'h00);
      wr_reg(A_CL, 8'h00);
      wr_reg(A_C0, 8'h81); // enable and software bit set
      rd_chk(A_C0, 8'hA1);
      wr_reg(A_C0, 8'h80);
      rd_chk(A_C0, 8'h80);
      wr_reg(A_C0, 8'h90);
      rd_chk(A_C0, 8'hB0);
   endtask
   task automatic t_sync();
      wr_reg(A_C1, 8'h10);
      wr_reg(A_C0, 8'h81);
      out_is(1'b1);
      wr_reg(A_C0, 8'h80);
      out_is(1'b1);
      ph <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      ph <= 1'b1;
      out_is(1'b0);
      wr_reg(A_C1, 8'h01);
      pl <= 1'b1;
      ph <= 1'b0;
      wr_reg(A_C0, 8'h81);
      out_is(1'b1);
      pl <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      pl <= 1'b1;
      out_is(1'b0);
   endtask
   task automatic t_clear();
      ph <= 1'b1;
      out_is(1'b1);
      peripheral_disable_unit <= 1'b1;
      wr_reg(A_SRC, 8'h05);
      rd_chk(A_C0, 8'h00);
      watch(4);
      peripheral_disable_unit <= 1'b0;
      rd_chk(A_SRC, 8'h00);
      rd_chk(A_C1, 8'h00);
      wr_reg(A_CH, 8'h03);
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd_chk(A_CH, 8'h00);
      rd_chk(A_C0, 8'h00);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_mux();
      t_enable();
      t_soft();
      t_sync();
      t_clear();
      test_done();
   end
endmodule
